// ### bench/wdic_top_asserts.sv
// Port checker for the watchdog block
`timescale 1ns/100ps
`include "wdic_defines.svh"
module wdic_top_asserts #(
  parameter int TICK_CYCLES = `WDIC_TICK_CYCLES,
  parameter logic [7:0] PULSE_CYCLES = `WDIC_PULSE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  input wire logic [10:0] irq_out,
  input wire logic nmi_out,
  input wire logic sys_reset_out,
  input wire logic unlocked
);
  // Data port read and write strobes
  wire logic dr = io_rd && io_addr == 8'h23;
  wire logic dw = io_wr && io_addr == 8'h23;
  // Any timeout action output
  wire logic act = |{irq_out, nmi_out, sys_reset_out};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_ans; dr |=> io_rvalid; endproperty
  a_ans: assert property (p_ans) else $error("read not answered");
  property p_only; !dr |=> !io_rvalid; endproperty
  a_only: assert property (p_only) else $error("stray read valid");
  property p_idle; !io_rvalid |-> io_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_lrd; dr && !unlocked |=> io_rdata == 8'h00; endproperty
  a_lrd: assert property (p_lrd) else $error("locked read leaked");
  property p_open; $rose(unlocked) |-> $past(dw) && $past(io_wdata) == 8'hc5; endproperty
  a_open: assert property (p_open) else $error("opened without key");
  property p_close; $fell(unlocked) |-> $past(dw) && $past(io_wdata) == 8'h00; endproperty
  a_close: assert property (p_close) else $error("closed without zero");
  property p_one; $onehot0({irq_out, nmi_out, sys_reset_out}); endproperty
  a_one: assert property (p_one) else $error("several actions");
  property p_len; $rose(act) |-> act [*8] ##1 act [*8] ##1 !act; endproperty
  a_len: assert property (p_len) else $error("action pulse length");
endmodule : wdic_top_asserts
bind wdic_top wdic_top_asserts #(.TICK_CYCLES(TICK_CYCLES), .PULSE_CYCLES(PULSE_CYCLES)) i_chk (
  .clk_sys(clk_sys), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .irq_out(irq_out),
  .nmi_out(nmi_out), .sys_reset_out(sys_reset_out), .unlocked(unlocked));

// ### bench/wdic_top_tb.sv
// Self-checking bench of the watchdog block
`timescale 1ns/100ps
module wdic_top_tb;
  localparam int TC = 4; // Shortened tick divider
  localparam int N = 6; // Count for timeouts, period 24 cycles
  logic clk_sys = 1'b0, rst = 1'b1, io_wr = 1'b0, io_rd = 1'b0, hit;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata, q;
  logic io_rvalid, nmi_out, sys_reset_out, unlocked;
  logic [10:0] irq_out;
  logic [23:0] v;
  time t0, t1;
  int failures = 0, n_tests = 0;
  // All actions as one vector
  wire logic [12:0] acts = {sys_reset_out, nmi_out, irq_out};
  wdic_top #(.TICK_CYCLES(TC), .PULSE_CYCLES(8'h10)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid), .irq_out(irq_out),
    .nmi_out(nmi_out), .sys_reset_out(sys_reset_out), .unlocked(unlocked));
  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;
  // Compare and count
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One-cycle port access, write or read
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    io_wr <= w;
    io_rd <= !w;
    io_addr <= a;
    io_wdata <= d;
    @(posedge clk_sys);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
  endtask : acc
  // Indexed register write
  task wr(input logic [7:0] i, input logic [7:0] d);
    acc(1'b1, 8'h22, i);
    acc(1'b1, 8'h23, d);
    #1;
  endtask : wr
  // Indexed register read into q
  task rd(input logic [7:0] i);
    acc(1'b1, 8'h22, i);
    acc(1'b0, 8'h23, 8'h00);
    #1;
    chk(io_rvalid, 1'b1);
    q = io_rdata;
  endtask : rd
  // Wait for the next rising action, bounded
  task wait_rise(output time t);
    int k;
    k = 0;
    while (|acts === 1'b1 && k < 40)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    k = 0;
    while (|acts !== 1'b1 && k < 80)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    t = $time;
  endtask : wait_rise
  // Expected action vector for a selection code
  function automatic logic [12:0] exp_act(input logic [3:0] c);
    if (c >= 4'h1 && c <= 4'hb)
      return 13'h0001 << (c - 4'h1);
    if (c == 4'hc)
      return 13'h0800;
    if (c == 4'hd)
      return 13'h1000;
    return 13'h0000;
  endfunction : exp_act
  // Verdict and end of run
  task conclude;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  // Hang guard
  initial
  begin
    #100000;
    failures++;
    conclude;
  end
  // Main sequence
  initial
  begin
    void'($urandom(32'he2ea777f));
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk(unlocked, 1'b0);
    wr(8'h39, 8'h77);
    rd(8'h39);
    chk(q, 8'h00);
    wr(8'h13, 8'hc5);
    chk(unlocked, 1'b1);
    for (int i = 0; i < 7; i++)
    begin
      rd(8'h37 + i[7:0]);
      chk(q, (i >= 2 && i <= 4) ? 8'hff : 8'h00);
    end
    $display("lock and reset values done");
    repeat (4)
    begin
      v = 24'($urandom);
      for (int j = 0; j < 3; j++)
        wr(8'h39 + j[7:0], v[8*j +: 8]);
      for (int j = 0; j < 3; j++)
      begin
        rd(8'h39 + j[7:0]);
        chk(q, v[8*j +: 8]);
      end
    end
    $display("count bytes done");
    wr(8'h39, N[7:0]);
    wr(8'h3a, 8'h00);
    wr(8'h3b, 8'h00);
    wr(8'h38, 8'h10);
    wait_rise(t0);
    chk(acts, 13'h0000);
    wr(8'h37, 8'h2d);
    // disable, restart, select, enable in order
    for (int c = 0; c < 16; c++)
    begin
      rd(8'h37);
      wr(8'h37, q & 8'hbf);
      wr(8'h3c, 8'h40);
      rd(8'h38);
      wr(8'h38, {c[3:0], q[3:0]});
      rd(8'h37);
      wr(8'h37, q | 8'h40);
      rd(8'h37);
      chk(q, 8'h6d);
      wait_rise(t0);
      chk(acts, exp_act(c[3:0]));
      wait_rise(t1);
      if (exp_act(c[3:0]) != 13'h0000)
        chk(24'(t1 - t0), 24'(N * TC * 5));
      rd(8'h3c);
      chk(q, 8'h80);
    end
    $display("actions done");
    wr(8'h3c, 8'h40);
    rd(8'h3c);
    chk(q, 8'h00);
    wr(8'h38, 8'hd0);
    hit = 1'b0;
    repeat (8)
    begin
      wr(8'h3c, 8'h40);
      repeat (8) @(posedge clk_sys);
      #1;
      hit = hit | sys_reset_out;
    end
    chk(hit, 1'b0);
    wait_rise(t0);
    chk(acts, 13'h1000);
    $display("restart done");
    wr(8'h13, 8'h5a);
    chk(unlocked, 1'b1);
    wr(8'h13, 8'h00);
    chk(unlocked, 1'b0);
    wr(8'h39, 8'h55);
    wr(8'h13, 8'hc5);
    rd(8'h39);
    chk(q, N[7:0]);
    $display("relock done");
    conclude;
  end
endmodule : wdic_top_tb

// ### common/wdic_defines.svh
// Offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WDIC_DEFINES_SVH
`define WDIC_DEFINES_SVH
// I/O port addresses of the index and data ports
`define WDIC_PORT_INDEX 8'h22
`define WDIC_PORT_DATA 8'h23
// Lock control index and key values
`define WDIC_LOCK_INDEX 8'h13
`define WDIC_UNLOCK_KEY 8'hc5
`define WDIC_LOCK_KEY 8'h00
// Register indices
`define WDIC_IDX_ENABLE 8'h37
`define WDIC_IDX_ACTION 8'h38
`define WDIC_IDX_CNT_LO 8'h39
`define WDIC_IDX_CNT_MID 8'h3a
`define WDIC_IDX_CNT_HI 8'h3b
`define WDIC_IDX_STATUS 8'h3c
// Field positions
`define WDIC_EN_BIT 6
`define WDIC_ACT_MSB 7
`define WDIC_ACT_LSB 4
`define WDIC_ST_TIMEOUT_BIT 7
`define WDIC_ST_RESTART_BIT 6
// Reset values
`define WDIC_RST_ENABLE 8'h00
`define WDIC_RST_ACTION 8'h00
`define WDIC_RST_COUNT 24'hffffff
`define WDIC_RST_STATUS 8'h00
// Action encodings
`define WDIC_ACT_NMI 4'hc
`define WDIC_ACT_SYSRST 4'hd
`define WDIC_ACT_IRQ_LAST 4'hb
// Tick timing: 32.768 kHz source, period in picoseconds
`define WDIC_TICK_PERIOD_PS 30517578
`define WDIC_CLK_PERIOD_PS 5000
`define WDIC_TICK_CYCLES (`WDIC_TICK_PERIOD_PS / `WDIC_CLK_PERIOD_PS)
// Width of action pulses in system clocks
`define WDIC_PULSE_CYCLES 8'h10
`endif

// ### common/wdic_pkg.sv
// Types shared by the watchdog block
package wdic_pkg;
  // Host access sequencer state for the index/data port pair
  typedef enum logic [1:0] {
    WDIC_LOCKED,
    WDIC_KEY_WAIT,
    WDIC_OPEN,
    WDIC_RELOCK_WAIT
  } wdic_lock_t;
  // Decoded timeout action
  typedef enum logic [1:0] {
    WDIC_DO_NONE,
    WDIC_DO_IRQ,
    WDIC_DO_NMI,
    WDIC_DO_SYSRST
  } wdic_act_t;
endpackage : wdic_pkg

// ### hdl/wdic_tick_gen.sv
// Divider producing the 32.768 kHz watchdog count tick
`timescale 1ns/100ps
`include "wdic_defines.svh"
module wdic_tick_gen #(
  parameter int TICK_CYCLES = `WDIC_TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  output logic tick
);
  // Cycle counter of one tick period
  logic [31:0] div_reg;
  // Count up cycles and pulse tick once per period
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      div_reg <= 32'h0;
      tick <= 1'b0;
    end
    else if (div_reg >= 32'(TICK_CYCLES - 1))
    begin
      div_reg <= 32'h0;
      tick <= 1'b1;
    end
    else
    begin
      div_reg <= div_reg + 32'h1;
      tick <= 1'b0;
    end
  end
endmodule : wdic_tick_gen

// ### hdl/wdic_top.sv
// Watchdog with indexed configuration space behind an index/data I/O port pair
`timescale 1ns/100ps
`include "wdic_defines.svh"
// How it works
// - Data port accesses ignored until unlock index and key; index writes always latched
// - Lock index then zero byte relocks
// - Data port read returns indexed register
// - Next data port write stores indexed register
// - Enable bit 6 starts or stops counting
// - Action nibble selects IRQ, NMI, reset, none
// - Count is three bytes, low index LSB
// - Each count unit adds one tick period
// - Status bit 7 shows timeout occurred
// - Writing 1 to status bit 6 restarts
// - Counter runs from 32.768 kHz tick
// - Selected IRQ fires on every expiry
module wdic_top
  import wdic_pkg::*;
#(
  parameter int TICK_CYCLES = `WDIC_TICK_CYCLES,
  parameter logic [7:0] PULSE_CYCLES = `WDIC_PULSE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  output logic [10:0] irq_out,
  output logic nmi_out,
  output logic sys_reset_out,
  output logic unlocked
);
  // Lock sequencer state and its next value
  wdic_lock_t lock_reg, lock_next;
  // Index latched from the index port
  logic [7:0] index_reg;
  // Configuration registers
  logic [7:0] enable_reg;
  logic [7:0] action_reg;
  logic [23:0] count_cfg_reg;
  logic [5:0] status_other_reg;
  logic timeout_reg;
  // Running down-counter
  logic [23:0] cnt_reg;
  // Action pulse width counter and the action that is being driven
  logic [7:0] pulse_reg;
  logic [3:0] fired_act_reg;
  // Tick from the divider
  logic tick;
  // Decoded strobes
  logic idx_wr, dat_wr, dat_rd, cfg_wr, restart_wr, expire;

  // Decode of the action nibble into an action kind
  function automatic wdic_act_t act_kind(input logic [3:0] code);
    if (code == 4'h0)
      return WDIC_DO_NONE;
    else if (code <= `WDIC_ACT_IRQ_LAST)
      return WDIC_DO_IRQ;
    else if (code == `WDIC_ACT_NMI)
      return WDIC_DO_NMI;
    else if (code == `WDIC_ACT_SYSRST)
      return WDIC_DO_SYSRST;
    else
      return WDIC_DO_NONE;
  endfunction : act_kind

  // Tick divider for the count clock
  // tick source instance
  wdic_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(tick)
  );

  // Port strobes
  assign idx_wr = io_wr && (io_addr == `WDIC_PORT_INDEX);
  assign dat_wr = io_wr && (io_addr == `WDIC_PORT_DATA);
  assign dat_rd = io_rd && (io_addr == `WDIC_PORT_DATA);
  assign cfg_wr = dat_wr && (lock_reg == WDIC_OPEN);
  // restart only on a written one
  assign restart_wr = cfg_wr && (index_reg == `WDIC_IDX_STATUS)
                      && io_wdata[`WDIC_ST_RESTART_BIT];
  // expiry when counting reaches last unit
  assign expire = enable_reg[`WDIC_EN_BIT] && tick && (cnt_reg <= 24'h1) && !restart_wr;

  // Index latch, always accepted so the lock index can be written
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      index_reg <= 8'h00;
    else if (idx_wr)
      index_reg <= io_wdata;
  end

  // Lock sequencer next state
  always_comb
  begin
    lock_next = lock_reg;
    case (lock_reg)
      // lock index written while locked arms the key
      WDIC_LOCKED:
        if (idx_wr && io_wdata == `WDIC_LOCK_INDEX)
          lock_next = WDIC_KEY_WAIT;
      // key opens the space, other data or an index other than the lock index drops back
      WDIC_KEY_WAIT:
        if (dat_wr)
          lock_next = (io_wdata == `WDIC_UNLOCK_KEY) ? WDIC_OPEN : WDIC_LOCKED;
        else if (idx_wr && io_wdata != `WDIC_LOCK_INDEX)
          lock_next = WDIC_LOCKED;
      // lock index while open arms relock
      WDIC_OPEN:
        if (idx_wr && io_wdata == `WDIC_LOCK_INDEX)
          lock_next = WDIC_RELOCK_WAIT;
      // zero byte relocks, other data keeps it open
      WDIC_RELOCK_WAIT:
        if (dat_wr)
          lock_next = (io_wdata == `WDIC_LOCK_KEY) ? WDIC_LOCKED : WDIC_OPEN;
        else if (idx_wr && io_wdata != `WDIC_LOCK_INDEX)
          lock_next = WDIC_OPEN;
      default:
        lock_next = WDIC_LOCKED;
    endcase
  end

  // Lock state register and its visible flag
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      lock_reg <= WDIC_LOCKED;
      unlocked <= 1'b0;
    end
    else
    begin
      lock_reg <= lock_next;
      unlocked <= (lock_next == WDIC_OPEN) || (lock_next == WDIC_RELOCK_WAIT);
    end
  end

  // Configuration register writes
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      enable_reg <= `WDIC_RST_ENABLE;
      action_reg <= `WDIC_RST_ACTION;
      count_cfg_reg <= `WDIC_RST_COUNT;
      status_other_reg <= 6'(`WDIC_RST_STATUS);
    end
    else if (cfg_wr)
    begin
      if (index_reg == `WDIC_IDX_ENABLE)
        enable_reg <= io_wdata;
      else if (index_reg == `WDIC_IDX_ACTION)
        action_reg <= io_wdata;
      // low index holds least significant byte
      else if (index_reg == `WDIC_IDX_CNT_LO)
        count_cfg_reg[7:0] <= io_wdata;
      else if (index_reg == `WDIC_IDX_CNT_MID)
        count_cfg_reg[15:8] <= io_wdata;
      else if (index_reg == `WDIC_IDX_CNT_HI)
        count_cfg_reg[23:16] <= io_wdata;
      else if (index_reg == `WDIC_IDX_STATUS)
        status_other_reg <= io_wdata[5:0];
    end
  end

  // Timeout flag: expiry sets it, a restart write clears it, clear wins
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      timeout_reg <= 1'b0;
    // flag records that a timeout occurred
    else if (expire)
      timeout_reg <= 1'b1;
    else if (restart_wr)
      timeout_reg <= 1'b0;
  end

  // Down-counter, one unit per tick while enabled
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      cnt_reg <= `WDIC_RST_COUNT;
    else if (restart_wr)
      cnt_reg <= count_cfg_reg;
    // disabled counter holds the programmed period
    else if (!enable_reg[`WDIC_EN_BIT])
      cnt_reg <= count_cfg_reg;
    else if (expire)
      cnt_reg <= count_cfg_reg;
    else if (tick)
      cnt_reg <= cnt_reg - 24'h1;
  end

  // Action pulse stretcher
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pulse_reg <= 8'h00;
      fired_act_reg <= 4'h0;
    end
    // every expiry fires the selected action again
    else if (expire)
    begin
      pulse_reg <= PULSE_CYCLES;
      fired_act_reg <= action_reg[`WDIC_ACT_MSB:`WDIC_ACT_LSB];
    end
    else if (pulse_reg != 8'h00)
      pulse_reg <= pulse_reg - 8'h01;
  end

  // Action outputs
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      irq_out <= 11'h000;
      nmi_out <= 1'b0;
      sys_reset_out <= 1'b0;
    end
    else
    begin
      // one-hot IRQ line from codes 1 to 11
      irq_out <= 11'h000;
      if ((pulse_reg != 8'h00) && act_kind(fired_act_reg) == WDIC_DO_IRQ)
        irq_out <= 11'(11'h001 << (fired_act_reg - 4'h1));
      nmi_out <= (pulse_reg != 8'h00) && act_kind(fired_act_reg) == WDIC_DO_NMI;
      sys_reset_out <= (pulse_reg != 8'h00) && act_kind(fired_act_reg) == WDIC_DO_SYSRST;
    end
  end

  // Data port read, returns zero while locked
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      io_rdata <= 8'h00;
      io_rvalid <= 1'b0;
    end
    else
    begin
      io_rvalid <= dat_rd;
      io_rdata <= 8'h00;
      // indexed register contents on data read
      if (dat_rd && lock_reg == WDIC_OPEN)
      begin
        if (index_reg == `WDIC_IDX_ENABLE)
          io_rdata <= enable_reg;
        else if (index_reg == `WDIC_IDX_ACTION)
          io_rdata <= action_reg;
        else if (index_reg == `WDIC_IDX_CNT_LO)
          io_rdata <= count_cfg_reg[7:0];
        else if (index_reg == `WDIC_IDX_CNT_MID)
          io_rdata <= count_cfg_reg[15:8];
        else if (index_reg == `WDIC_IDX_CNT_HI)
          io_rdata <= count_cfg_reg[23:16];
        // timeout flag in bit 7, restart bit reads zero
        else if (index_reg == `WDIC_IDX_STATUS)
          io_rdata <= {timeout_reg, 1'b0, status_other_reg};
      end
    end
  end
endmodule : wdic_top
